// >>> verilog/sync_setup_key.v
`timescale 1ns/1ps
`include "sync_setup_key_defs.vh"
// Notes on behaviour
// - At most one master while locking is on.
// - Enabling locking issues a lock pulse.
// - Locked channels need continuous run mode.
// - Synthesis waveforms use master's synthesis clock.
// - PLL waveforms use master's PLL clock.
// - Roles independent, master, tracking master, slave.
// - Refuse lock with zero or several masters.
// - Tracking master frequency copies to slaves, relock.
// - Tracking needs equal frequencies at enable.
// - PLL master in plain role becomes tracking.
// - Refuse mixing synthesis and PLL waveforms.
// - Refuse enable when locked frequency too high.
// - Reject high frequency request, keep lock.
// - Positive phase advances, negative delays slave.
// - Offset is slave phase minus master phase.
// - Synthesis phase range 360 degrees, 0.1 steps.
// - Per-waveform locked frequency limits.
// - Arbitrary resolution is 360 over length, no finer than 0.1 degree.
// - Pulse, train, sequence phase held zero.
// - Relock after a phase change or an accepted frequency write, but not after a phase change during a rejected write.
// - Unequal arbitrary lengths are never refused.
module sync_setup_key (
  input wire clk_sys_in,
  input wire rst_in,
  input wire ce_in,
  input wire [`NCH*`ROLE_W-1:0] role_in,
  input wire [`NCH*`WAVE_W-1:0] wave_in,
  input wire [`NCH-1:0] cont_mode_in,
  input wire [`NCH*`FREQ_W-1:0] freq_in,
  input wire [`NCH*`PHASE_W-1:0] phase_in,
  input wire [`NCH*`LEN_W-1:0] arb_len_in,
  input wire lock_on_in,
  input wire lock_off_in,
  input wire freq_wr_in,
  input wire [1:0] freq_wr_ch_in,
  input wire [`FREQ_W-1:0] freq_wr_val_in,
  input wire dds_clk_in,
  input wire pll_clk_in,
  output reg lock_active_out,
  output reg lock_pulse_out,
  output reg [`ERR_W-1:0] error_out,
  output reg [`NCH*`ROLE_W-1:0] role_eff_out,
  output reg [`NCH*`FREQ_W-1:0] freq_out,
  output reg [`NCH-1:0] ref_sel_pll_out,
  output reg [`NCH-1:0] ref_clk_out,
  output wire [`NCH*(`PHASE_W+1)-1:0] offset_out,
  output reg [`NCH*`LEN_W-1:0] phase_step_out
);
  // ======================================================================
  // Reference clock synchronisers
  reg [1:0] dds_sync_reg;
  reg [1:0] pll_sync_reg;
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      dds_sync_reg <= 2'h0;
      pll_sync_reg <= 2'h0;
    end else if (ce_in) begin
      dds_sync_reg <= {dds_sync_reg[0], dds_clk_in};
      pll_sync_reg <= {pll_sync_reg[0], pll_clk_in};
    end
  end
  // ======================================================================
  // Current frequencies held by the block
  reg [`NCH*`FREQ_W-1:0] freq_reg;
  function [`FREQ_W-1:0] freq_reg_f;
    input integer c;
    begin
      freq_reg_f = freq_reg[c*`FREQ_W +: `FREQ_W];
    end
  endfunction
  // ======================================================================
  // Per-channel decode
  reg [`NCH-1:0] is_master;
  reg [`NCH-1:0] is_locked;
  reg [`NCH-1:0] is_pll;
  reg [`NCH-1:0] too_fast;
  reg [2:0] n_master;
  reg [1:0] master_ch;
  reg any_tracking;
  reg [`FREQ_W-1:0] mfreq;
  reg [`WAVE_W-1:0] wv;
  reg [`FREQ_W-1:0] lim;
  integer i;
  function [`FREQ_W-1:0] flimit;
    input [`WAVE_W-1:0] w;
    begin
      case (w)
        `WV_SINE: flimit = `F_SINE_MAX;
        `WV_SQUARE: flimit = `F_SQUARE_MAX;
        `WV_TRI, `WV_RAMP, `WV_SINC: flimit = `F_SLOW_MAX;
        default: flimit = `F_PLL_MAX;
      endcase
    end
  endfunction
  function pll_wave;
    input [`WAVE_W-1:0] w;
    begin
      pll_wave = (w == `WV_SQUARE || w == `WV_PULSE || w == `WV_PTRAIN || w == `WV_ARB || w == `WV_SEQ);
    end
  endfunction
  always @* begin
    is_master = {`NCH{1'b0}};
    is_locked = {`NCH{1'b0}};
    is_pll = {`NCH{1'b0}};
    too_fast = {`NCH{1'b0}};
    n_master = 3'h0;
    master_ch = 2'h0;
    any_tracking = 1'b0;
    wv = `WV_SINE;
    lim = `F_SINE_MAX;
    for (i = 0; i < `NCH; i = i + 1) begin
      wv = wave_in[i*`WAVE_W +: `WAVE_W];
      lim = flimit(wv);
      is_pll[i] = pll_wave(wv);
      is_master[i] = role_in[i*`ROLE_W +: `ROLE_W] == `ROLE_MASTER || role_in[i*`ROLE_W +: `ROLE_W] == `ROLE_MFREQ;
      is_locked[i] = role_in[i*`ROLE_W +: `ROLE_W] != `ROLE_INDEP;
      too_fast[i] = freq_reg_f(i) > lim;
      if (is_master[i]) begin
        n_master = n_master + 3'h1;
        master_ch = i[1:0];
        // a PLL master in plain role is promoted to tracking.
        if (role_in[i*`ROLE_W +: `ROLE_W] == `ROLE_MFREQ || is_pll[i]) begin
          any_tracking = 1'b1;
        end
      end
    end
    mfreq = freq_reg_f(master_ch);
  end
  // ======================================================================
  // Enable checks
  reg [`ERR_W-1:0] chk;
  wire multi_bad = n_master > 3'h1;
  wire none_bad = n_master == 3'h0;
  wire mix_bad = |(is_locked & is_pll) && |(is_locked & ~is_pll);
  wire run_bad = |(is_locked & ~cont_mode_in);
  wire fast_bad = |(is_locked & too_fast);
  reg track_bad;
  always @* begin
    track_bad = 1'b0;
    for (i = 0; i < `NCH; i = i + 1) begin
      if (any_tracking && is_locked[i] && freq_reg_f(i) != mfreq) begin
        track_bad = 1'b1;
      end
    end
  end
  always @* begin
    chk = {`ERR_W{1'b0}};
    chk[`E_MULTI] = multi_bad;
    chk[`E_NOMASTER] = none_bad;
    chk[`E_MIX] = mix_bad;
    chk[`E_RUNMODE] = run_bad;
    chk[`E_FHIGH] = fast_bad;
    chk[`E_FTRACK] = track_bad;
    // arbitrary length mismatch is deliberately not checked.
  end
  // ======================================================================
  // Change detection for relocking
  reg [`NCH*`PHASE_W-1:0] phase_prev_reg;
  wire phase_changed = phase_prev_reg != phase_in;
  reg [`FREQ_W-1:0] req_lim;
  reg req_ok;
  always @* begin
    req_lim = flimit(wave_in[freq_wr_ch_in*`WAVE_W +: `WAVE_W]);
    req_ok = freq_wr_val_in <= req_lim;
  end
  // ======================================================================
  // Next effective roles, with PLL masters promoted
  reg [`NCH*`ROLE_W-1:0] role_eff_next;
  always @* begin
    role_eff_next = role_in;
    for (i = 0; i < `NCH; i = i + 1) begin
      if (role_in[i*`ROLE_W +: `ROLE_W] == `ROLE_MASTER && is_pll[i]) begin
        role_eff_next[i*`ROLE_W +: `ROLE_W] = `ROLE_MFREQ;
      end
    end
  end
  // ======================================================================
  // Request decode
  // A lock-off request wins over a lock-on request in the same cycle.
  wire take_off = lock_off_in;
  wire take_on = !lock_off_in && lock_on_in && !lock_active_out;
  wire chk_clean = chk == {`ERR_W{1'b0}};
  wire enable_ok = take_on && chk_clean;
  wire enable_bad = take_on && !chk_clean;
  // Writes and phase changes count only while locked and not being released.
  wire locked_hold = !lock_off_in && lock_active_out;
  wire wr_locked = locked_hold && freq_wr_in;
  wire wr_good = wr_locked && req_ok;
  wire wr_high = wr_locked && !req_ok;
  wire phase_relock = locked_hold && !freq_wr_in && phase_changed;
  // A tracking master spreads its new frequency to all locked channels.
  wire track_copy = freq_wr_ch_in == master_ch && any_tracking;
  // ======================================================================
  // Lock status
  // The lock level stands until the host releases it.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      lock_active_out <= 1'b0;
    end else if (ce_in) begin
      if (take_off) begin
        lock_active_out <= 1'b0;
      end else if (enable_ok) begin
        lock_active_out <= 1'b1;
      end
    end
  end
  // ======================================================================
  // Lock pulse
  // The pulse stands for one cycle after an enable, a good write or a phase change.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      lock_pulse_out <= 1'b0;
    end else if (ce_in) begin
      if (enable_ok) begin
        lock_pulse_out <= 1'b1;
      end else if (wr_good || phase_relock) begin
        lock_pulse_out <= 1'b1;
      end else begin
        lock_pulse_out <= 1'b0;
      end
    end
  end
  // ======================================================================
  // Error flags
  // Error bits hold until the next enable, which clears them if every check passes and otherwise loads the failed checks; a rejected locked write sets E_FREQREQ.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      error_out <= {`ERR_W{1'b0}};
    end else if (ce_in) begin
      if (enable_ok) begin
        error_out <= {`ERR_W{1'b0}};
      end else if (enable_bad) begin
        error_out <= chk;
      end else if (wr_high) begin
        error_out[`E_FREQREQ] <= 1'b1;
      end
    end
  end
  // ======================================================================
  // Effective roles
  // Roles follow the host while unlocked and freeze once lock is taken.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      role_eff_out <= {`NCH{`ROLE_INDEP}};
    end else if (ce_in) begin
      if (enable_ok) begin
        role_eff_out <= role_eff_next;
      end else if (!lock_active_out) begin
        role_eff_out <= role_in;
      end
    end
  end
  // ======================================================================
  // Frequency next value
  // Frequencies follow the host inputs while unlocked.
  // While locked only an accepted write changes them, so a rejected one keeps the old value.
  reg [`NCH*`FREQ_W-1:0] freq_next;
  integer k;
  always @* begin
    freq_next = freq_reg;
    if (!lock_active_out) begin
      freq_next = freq_in;
    end else if (wr_good) begin
      if (track_copy) begin
        for (k = 0; k < `NCH; k = k + 1) begin
          if (is_locked[k]) begin
            freq_next[k*`FREQ_W +: `FREQ_W] = freq_wr_val_in;
          end
        end
      end else begin
        freq_next[freq_wr_ch_in*`FREQ_W +: `FREQ_W] = freq_wr_val_in;
      end
    end
  end
  // ======================================================================
  // Frequency register
  // The held frequencies are what the limit checks judge at enable.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      freq_reg <= {(`NCH*`FREQ_W){1'b0}};
    end else if (ce_in) begin
      freq_reg <= freq_next;
    end
  end
  // ======================================================================
  // Phase history
  // The previous phases let a change be seen in the same cycle that it arrives.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      phase_prev_reg <= {(`NCH*`PHASE_W){1'b0}};
    end else if (ce_in) begin
      phase_prev_reg <= phase_in;
    end
  end
  always @* begin
    freq_out = freq_reg;
  end
  // ======================================================================
  // Reference clock distribution
  always @* begin
    for (i = 0; i < `NCH; i = i + 1) begin
      ref_sel_pll_out[i] = is_pll[master_ch];
      ref_clk_out[i] = is_pll[master_ch] ? pll_sync_reg[1] : dds_sync_reg[1];
    end
  end
  // ======================================================================
  // Phase resolution per channel
  always @* begin
    for (i = 0; i < `NCH; i = i + 1) begin
      // arbitrary steps are one point below ARB_FINE_LEN points; synthesis and longer arbitrary steps are 0.1 degree.
      if (wave_in[i*`WAVE_W +: `WAVE_W] == `WV_ARB && arb_len_in[i*`LEN_W +: `LEN_W] < `ARB_FINE_LEN) begin
        phase_step_out[i*`LEN_W +: `LEN_W] = arb_len_in[i*`LEN_W +: `LEN_W];
      end else begin
        phase_step_out[i*`LEN_W +: `LEN_W] = `ARB_FINE_LEN;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < `NCH; g = g + 1) begin : g_off
      chan_offset u_off (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .own_phase_in(phase_in[g*`PHASE_W +: `PHASE_W]),
        .master_phase_in(phase_in[master_ch*`PHASE_W +: `PHASE_W]),
        .wave_in(wave_in[g*`WAVE_W +: `WAVE_W]),
        .offset_out(offset_out[g*(`PHASE_W+1) +: (`PHASE_W+1)])
      );
    end
  endgenerate
endmodule // sync_setup_key

// >>> verilog/sync_setup_key_defs.vh
`ifndef SYNC_SETUP_KEY_DEFS_VH
`define SYNC_SETUP_KEY_DEFS_VH
// ======================================================================
// Channel count and field widths
`define NCH 4
`define ROLE_W 2
`define WAVE_W 4
`define FREQ_W 32
`define PHASE_W 13
`define LEN_W 16
`define ERR_W 8
// ======================================================================
// Channel roles
`define ROLE_INDEP 2'h0
`define ROLE_MASTER 2'h1
`define ROLE_MFREQ 2'h2
`define ROLE_SLAVE 2'h3
// ======================================================================
// Waveform kinds
`define WV_SINE 4'h0
`define WV_SQUARE 4'h1
`define WV_TRI 4'h2
`define WV_RAMP 4'h3
`define WV_SINC 4'h4
`define WV_PULSE 4'h5
`define WV_PTRAIN 4'h6
`define WV_ARB 4'h7
`define WV_SEQ 4'h8
// ======================================================================
// Frequency limits in Hz, phase in tenths of a degree
`define F_SINE_MAX 32'h00989680
`define F_SQUARE_MAX 32'h00f42400
`define F_SLOW_MAX 32'h000186a0
`define F_PLL_MAX 32'h00989680
`define PH_FULL 13'h0e10
`define PH_ZERO 13'h0000
`define ARB_FINE_LEN 16'h0e10
// ======================================================================
// Error bits
`define E_MULTI 0
`define E_NOMASTER 1
`define E_MIX 2
`define E_FTRACK 3
`define E_RUNMODE 4
`define E_FHIGH 5
`define E_FREQREQ 6
`define E_PHASE 7
`endif

// >>> verilog/chan_offset.v
`timescale 1ns/1ps
`include "sync_setup_key_defs.vh"
module chan_offset (
  input wire clk_sys_in,
  input wire rst_in,
  input wire ce_in,
  input wire signed [`PHASE_W-1:0] own_phase_in,
  input wire signed [`PHASE_W-1:0] master_phase_in,
  input wire [`WAVE_W-1:0] wave_in,
  output reg signed [`PHASE_W:0] offset_out
);
  reg signed [`PHASE_W:0] diff;
  always @* begin
    diff = {own_phase_in[`PHASE_W-1], own_phase_in} - {master_phase_in[`PHASE_W-1], master_phase_in};
    if (wave_in == `WV_PULSE || wave_in == `WV_PTRAIN || wave_in == `WV_SEQ || wave_in == `WV_SQUARE) begin
      diff = {1'b0, `PH_ZERO};
    end
  end
  // Positive result advances the channel relative to the master.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      offset_out <= {(`PHASE_W+1){1'b0}};
    end else if (ce_in) begin
      offset_out <= diff;
    end
  end
endmodule // chan_offset

// >>> sim/ref_clock_src.sv
`timescale 1ns/1ps
module ref_clock_src (
  output logic dds_clk_out,
  output logic pll_clk_out
);
  // ==========
  // Master references run free, unrelated in phase to the system clock.
  initial begin
    dds_clk_out = 1'b0;
    #3.3 forever #62.5 dds_clk_out = ~dds_clk_out;
  end
  initial begin
    pll_clk_out = 1'b0;
    #41.7 forever #62.5 pll_clk_out = ~pll_clk_out;
  end
endmodule // ref_clock_src

// >>> sim/sync_setup_key_asserts.sv
`timescale 1ns/1ps
module sync_setup_key_asserts (
  input clk_sys_in,
  input rst_in,
  input [7:0] role_in,
  input [15:0] wave_in,
  input [3:0] cont_mode_in,
  input lock_on_in,
  input lock_off_in,
  input freq_wr_in,
  input [31:0] freq_wr_val_in,
  input lock_active_out,
  input lock_pulse_out,
  input [7:0] error_out,
  input [127:0] freq_out,
  input [55:0] offset_out
);
  // ==========
  // Masters counted and run modes judged straight from the inputs.
  int nm;
  logic bad_run;
  wire req = lock_on_in && !lock_off_in && !lock_active_out;
  wire wr = lock_active_out && freq_wr_in && !lock_off_in;
  always_comb begin
    nm = 0;
    bad_run = 1'b0;
    for (int i = 0; i < 4; i++) begin
      nm += (role_in[2*i+:2] inside {2'h1, 2'h2});
      bad_run |= role_in[2*i+:2] != 2'h0 && !cont_mode_in[i];
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_enable_answer: assert property (req |=> lock_active_out && lock_pulse_out || !lock_active_out && error_out != 8'h00)
    else $error("no lock answer");
  a_no_master: assert property (req && nm == 0 |=> !lock_active_out && error_out[1]) else $error("no master taken");
  a_multi_master: assert property (req && nm > 1 |=> !lock_active_out && error_out[0]) else $error("two masters");
  a_run_mode: assert property (req && bad_run |=> !lock_active_out && error_out[4]) else $error("run mode");
  a_high_request: assert property (wr && freq_wr_val_in > 32'h00f42400 |=> lock_active_out && error_out[6] && $stable(freq_out))
    else $error("high freq taken");
  a_write_relock: assert property (wr && freq_wr_val_in inside {[32'h1:32'h186a0]} |=> lock_pulse_out) else $error("no relock");
  a_pulse_zero: assert property ((wave_in[15:12] == 4'h5) [*2] |-> offset_out[55:42] == 14'h0000) else $error("pulse phase");
  a_clear_errors: assert property ($rose(lock_active_out) |-> error_out == 8'h00) else $error("errors kept");
  cover property (req ##1 lock_active_out);
  cover property (req ##1 !lock_active_out);
  cover property (wr ##1 lock_pulse_out);
endmodule // sync_setup_key_asserts
bind sync_setup_key sync_setup_key_asserts u_chk (.*);

// >>> sim/test_sync_setup_key.sv
`timescale 1ns/1ps
module test_sync_setup_key;
  logic clk_sys_in, rst_in, ce_in, lock_on_in, lock_off_in, freq_wr_in;
  logic [7:0] role_in;
  logic [15:0] wave_in;
  logic [3:0] cont_mode_in;
  logic [127:0] freq_in;
  logic [51:0] phase_in;
  logic [63:0] arb_len_in;
  logic [1:0] freq_wr_ch_in;
  logic [31:0] freq_wr_val_in;
  wire dds_clk_in, pll_clk_in, lock_active_out, lock_pulse_out;
  wire [7:0] error_out, role_eff_out;
  wire [127:0] freq_out;
  wire [3:0] ref_sel_pll_out, ref_clk_out;
  wire [55:0] offset_out;
  wire [63:0] phase_step_out;
  int fails = 0;
  int num_checks = 0;
  sync_setup_key u_dut (.*);
  ref_clock_src u_ref (.dds_clk_out(dds_clk_in), .pll_clk_out(pll_clk_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // ==========
  // Shared drivers and comparison.
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick();
    @(negedge clk_sys_in);
  endtask
  // Drops any lock, loads a setup, then asks for lock for one edge.
  task automatic cfg(logic [7:0] r, logic [15:0] w, logic [3:0] c, logic [31:0] f1);
    tick();
    {role_in, wave_in, cont_mode_in, lock_off_in} = {r, w, c, 1'b1};
    freq_in = {32'h3e8, 32'h3e8, f1, 32'h3e8};
    tick();
    lock_off_in = 1'b0;
    tick();
    lock_on_in = 1'b1;
    tick();
    lock_on_in = 1'b0;
  endtask
  task automatic bad(logic [7:0] r, logic [15:0] w, logic [3:0] c, logic [31:0] f1, int b);
    cfg(r, w, c, f1);
    check("lock refused", lock_active_out, 0);
    check("error bit", error_out[b], 1);
  endtask
  task automatic wrf(logic [1:0] ch, logic [31:0] v);
    tick();
    {freq_wr_in, freq_wr_ch_in, freq_wr_val_in} = {1'b1, ch, v};
    tick();
    freq_wr_in = 1'b0;
  endtask
  // ==========
  // Scenarios.
  task automatic t_refusals();
    bad(8'h0c, 16'h0000, 4'hf, 32'h3e8, 1);
    bad(8'h05, 16'h0000, 4'hf, 32'h3e8, 0);
    bad(8'h0d, 16'h0000, 4'hd, 32'h3e8, 4);
    bad(8'h0d, 16'h0070, 4'hf, 32'h3e8, 2);
    bad(8'h0d, 16'h0000, 4'hf, 32'h00989681, 5);
    bad(8'h0d, 16'h0020, 4'hf, 32'h00030d40, 5);
    bad(8'h0e, 16'h0000, 4'hf, 32'h7d0, 3);
  endtask
  task automatic t_lock_phase();
    int n;
    phase_in = {13'h01f4, 13'h0000, 13'h1c7c, 13'h0384};
    cfg(8'h0d, 16'h5000, 4'hf, 32'h3e8);
    check("lock", lock_active_out, 1);
    check("lock pulse", lock_pulse_out, 1);
    check("errors", error_out, 0);
    check("synthesis ref", ref_sel_pll_out[1], 0);
    check("slave offset", offset_out[27:14], 14'h38f8);
    check("pulse offset", offset_out[55:42], 0);
    tick();
    check("pulse end", lock_pulse_out, 0);
    phase_in[25:13] = 13'h01c2;
    n = 0;
    while (lock_pulse_out !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    check("relock", lock_pulse_out, 1);
    check("advanced offset", offset_out[27:14], 14'h3e3e);
    if (n == 4) complete_run();
  endtask
  task automatic t_high_request();
    wrf(2'h1, 32'h00f42401);
    check("kept freq", freq_out[63:32], 32'h3e8);
    check("lock kept", lock_active_out, 1);
    check("request error", error_out[6], 1);
  endtask
  task automatic t_tracking();
    int n;
    arb_len_in = {32'h0, 16'h0400, 16'h1000};
    cfg(8'h0d, 16'h0077, 4'hf, 32'h3e8);
    check("unequal lengths", lock_active_out, 1);
    check("forced tracking", role_eff_out[1:0], 2'h2);
    check("pll ref", ref_sel_pll_out[1], 1);
    check("coarse arb step", phase_step_out[31:16], 16'h0400);
    check("fine arb step", phase_step_out[15:0], 16'h0e10);
    n = 0;
    while (ref_clk_out[1] !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    check("pll ref clock", ref_clk_out[1], 1);
    wrf(2'h0, 32'h7d0);
    check("slave follows", freq_out[63:32], 32'h7d0);
    check("tracking relock", lock_pulse_out, 1);
  endtask
  initial begin
    {rst_in, ce_in, cont_mode_in} = 6'h3f;
    {lock_on_in, lock_off_in, freq_wr_in, freq_wr_ch_in, freq_wr_val_in, role_in, wave_in, phase_in} = '0;
    freq_in = {4{32'h3e8}};
    arb_len_in = {4{16'h1000}};
    repeat (3) tick();
    rst_in = 1'b0;
    tick();
    check("default roles", role_eff_out, 0);
    t_refusals();
    t_lock_phase();
    t_high_request();
    t_tracking();
    complete_run();
  end
endmodule // test_sync_setup_key
